/* rtl/magtape_dma_controller.sv */
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
// Function
// R1 - Software presets two's complement count; each transfer increments; reaching zero is last.
// R2 - Space forward and reverse count records in the byte/record counter.
// R3 - Address counter steps per byte, ending one past last character.
// R4 - On bus error the address counter keeps the failing address.
// R5 - Seven-channel read keeps six data bits, upper two zero, no parity.
// R6 - Nine-channel read keeps all eight data bits.
// R7 - Read bytes go alternately to low and high halves of words.
// R8 - Nine-channel record end: select 0 gives cyclic, 1 longitudinal check.
// R9 - Seven-channel record end: select 1 longitudinal check, 0 last character.
// R10 - Seven-channel density 200, 556 or 800; nine-channel always 800.
// R11 - Controller drives parity polarity; transport makes the parity bit.
// R12 - Extended-gap write is a write that first erases three inches.
// R13 - End-of-file writes mark and equal check; 17 or 23 octal.
// R14 - End-of-file puts a three-inch gap first unless extended gap asserted.
// R15 - Status shows only the selected unit; other rewinds stay silent.
// R16 - Read strobe latches data and requests DMA; grant gives byte write.
// R17 - Write strobe requests DMA; grant gives read of one byte.
// R18 - Interrupt only with enable set; ready rising or rewind completion.
// R19 - Error summary with enable set requests an interrupt.
// R20 - Command written without go while enabled interrupts at once.
// R21 - Selected unit finishing rewind before new command interrupts when enabled.
// R22 - Rewind gives start and finish interrupts; one if already at start.
// R23 - Reset and controller clear select unit 0; rewinds carry on.
// R24 - Command write while not ready sets illegal and error flags.
// R25 - Reset drops DMA and interrupt requests and idles the sequencer.
module magtape_dma_controller
    import magtape_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // DMA master and interrupt request.
    output logic dma_req_o,
    input wire logic dma_gnt_i,
    output logic dma_cyc_o,
    output logic dma_we_o,
    output logic [AW-1:0] dma_adr_o,
    output logic [1:0] dma_sel_o,
    output logic [15:0] dma_dat_o,
    input wire logic [15:0] dma_dat_i,
    input wire logic dma_ack_i,
    input wire logic dma_err_i,
    output logic irq_o,
    input wire logic irq_ack_i,
    // Transport pins in.
    input wire logic read_strobe_i,
    input wire logic write_strobe_i,
    input wire logic eor_strobe_i,
    input wire logic op_done_i,
    input wire logic rewinding_i,
    input wire logic unit_ready_i,
    input wire logic tape_start_marker_i,
    input wire logic write_lock_i,
    input wire logic seven_ch_i,
    input wire logic [8:0] rd_char_i,
    input wire logic [7:0] crc_char_i,
    input wire logic [7:0] lrc_char_i,
    // Transport pins out.
    output logic [2:0] unit_sel_o,
    output logic [2:0] func_o,
    output logic go_pulse_o,
    output logic [1:0] density_o,
    output logic parity_even_o,
    output logic erase_gap_o,
    output logic [7:0] wr_data_o
);
    seq_state_t state_reg, state_next;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, filt_reg, raw_w;
    logic rds_f, wrs_f, eor_f, done_f, rew_f, selr_f, bot_f, wrl_f, sev_f;
    logic [8:0] chr_f;
    logic [7:0] crc_f, lrc_f;
    logic [3:0] prev_reg, rise_w;
    logic [15:0] brc_reg, brc_inc, cmd_rd, st_rd, rdl_rd, wmask, wmerge;
    logic [AW-1:0] cma_reg;
    logic [7:0] buf_reg;
    logic [8:0] rchr_reg;
    logic [2:0] func_reg, unit_reg;
    logic [1:0] dens_reg;
    logic ie_reg, rdy_reg, peven_reg, ilc_reg, nxm_reg, last_reg;
    logic csel_reg, pend_reg, ack_reg, go_reg, rew_seen_reg, err_prev_reg;
    logic acc, wr_en, cmd_wr, is_rd, is_wr, is_sp, ext_gap_cmd;
    logic start_ok, illegal, finish, rew_done, err_w, rdy_rise;

    // Pin sampling: three stages, and a change is taken only when stages two and three agree.
    assign raw_w = {read_strobe_i, write_strobe_i, eor_strobe_i, op_done_i, rewinding_i,
                    unit_ready_i, tape_start_marker_i, write_lock_i, seven_ch_i,
                    rd_char_i, crc_char_i, lrc_char_i};
    assign {rds_f, wrs_f, eor_f, done_f, rew_f, selr_f, bot_f, wrl_f, sev_f,
            chr_f, crc_f, lrc_f} = filt_reg;
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            s1_reg <= raw_w;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    // Strobe edges are taken from the filtered copies.
    assign rise_w = {rds_f, wrs_f, eor_f, done_f} & ~prev_reg;

    // Bus decode and read selection.
    assign acc = wb_cyc_i & wb_stb_i;
    assign wr_en = acc & wb_we_i & ack_reg & ce_i;
    assign cmd_wr = wr_en & (wb_adr_i == A_CMD);
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign err_w = ilc_reg | nxm_reg;
    assign cmd_rd = (16'(err_w) << C_ERR) | (16'(dens_reg) << C_DENS)
                  | (16'(peven_reg) << C_PEVEN) | (16'(unit_reg) << C_UNIT)
                  | (16'(rdy_reg) << C_RDY) | (16'(ie_reg) << C_IE)
                  | (16'(cma_reg[AW-1:16]) << C_XADR) | (16'(func_reg) << C_FUNC);
    // Status reflects only the selected unit, since the transport muxes its lines.
    assign st_rd = (16'(ilc_reg) << S_ILC) | (16'(nxm_reg) << S_NXM) // R15
                 | (16'(selr_f) << S_SELR) | (16'(bot_f) << S_BOT)
                 | (16'(sev_f) << S_7CH) | (16'(rew_f) << S_RWS) | (16'(wrl_f) << S_WRL);
    assign rdl_rd = (16'(csel_reg) << R_CSEL) | 16'(rchr_reg);

    // Byte-lane merge of write data into a register image.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [15:0] m);
        merge = (old & ~m) | (d & m);
    endfunction : merge
    assign wmerge = merge(cmd_rd, wb_dat_i[15:0], wmask);

    // Function decode.
    assign is_rd = (func_reg == F_READ);
    assign is_wr = (func_reg == F_WRITE) | (func_reg == F_WEXT); // R12
    assign is_sp = (func_reg == F_SPFWD) | (func_reg == F_SPREV);
    assign ext_gap_cmd = (func_reg == F_WEXT);
    assign illegal = ~selr_f | (wrl_f & (is_wr | (func_reg == F_WEOF)));
    assign start_ok = cmd_wr & rdy_reg & wmerge[C_GO] & ~wmerge[C_PCLR];
    assign brc_inc = brc_reg + ONE16;
    assign rdy_rise = (state_reg != ST_IDLE) & (state_next == ST_IDLE);

    // Sequencer next state.
    always_comb begin
        state_next = state_reg;
        finish = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_ok & ~illegal) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (rise_w[0] | (func_reg == F_REW)) begin
                    finish = 1'b1;
                end else if (is_rd & rise_w[1]) begin
                    finish = 1'b1;
                end else if (is_sp & rise_w[1] & (brc_inc == ZERO16)) begin
                    finish = 1'b1; // R2
                end else if ((is_rd & rise_w[3]) | (is_wr & rise_w[2])) begin
                    state_next = last_reg ? ST_RUN : ST_REQ; // R16 R17
                end
                if (finish) begin
                    state_next = ST_IDLE;
                end
            end
            ST_REQ: begin
                if (dma_gnt_i) begin
                    state_next = ST_BUS;
                end
            end
            ST_BUS: begin
                if (dma_err_i | (dma_ack_i & last_reg)) begin
                    state_next = ST_IDLE; // R1
                end else if (dma_ack_i) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Rewind completion for the selected unit, armed only while selection is unchanged.
    assign rew_done = rew_seen_reg & ~rew_f; // R21 R22

    // Wishbone answer: one registered ack per request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= acc & ~ack_reg;
            wb_dat_o <= {16'h0000,
                (wb_adr_i == A_STATUS) ? st_rd : (wb_adr_i == A_CMD) ? cmd_rd :
                (wb_adr_i == A_BRC) ? brc_reg : (wb_adr_i == A_CMA) ? cma_reg[15:0] :
                (wb_adr_i == A_DATA) ? {8'h00, buf_reg} :
                (wb_adr_i == A_RDL) ? rdl_rd : ZERO16};
        end
    end
    assign wb_ack_o = ack_reg;

    // Controller state: command fields, counters, data buffer and flags.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE; // R25
            func_reg <= F_OFFL;
            unit_reg <= UNIT0; // R23
            dens_reg <= D_800;
            ie_reg <= 1'b0;
            rdy_reg <= 1'b1;
            peven_reg <= 1'b0;
            ilc_reg <= 1'b0;
            nxm_reg <= 1'b0;
            last_reg <= 1'b0;
            csel_reg <= 1'b0;
            brc_reg <= ZERO16;
            cma_reg <= '0;
            buf_reg <= 8'h00;
            rchr_reg <= 9'h000;
            go_reg <= 1'b0;
            prev_reg <= 4'h0;
            rew_seen_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            prev_reg <= {rds_f, wrs_f, eor_f, done_f};
            go_reg <= 1'b0;
            rew_seen_reg <= rew_f ? 1'b1 : (rew_seen_reg & rew_f);
            if (rdy_rise) begin
                rdy_reg <= 1'b1;
            end
            // Software register writes.
            if (wr_en & (wb_adr_i == A_BRC)) begin
                brc_reg <= merge(brc_reg, wb_dat_i[15:0], wmask); // R1
            end
            if (wr_en & (wb_adr_i == A_CMA)) begin
                cma_reg[15:0] <= merge(cma_reg[15:0], wb_dat_i[15:0], wmask);
            end
            if (wr_en & (wb_adr_i == A_DATA)) begin
                buf_reg <= (buf_reg & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
            end
            if (wr_en & (wb_adr_i == A_RDL) & wb_sel_i[1]) begin
                csel_reg <= wb_dat_i[R_CSEL];
            end
            if (cmd_wr & ~rdy_reg) begin
                ilc_reg <= 1'b1; // R24
            end else if (cmd_wr & wmerge[C_PCLR]) begin
                unit_reg <= UNIT0; // R23
                state_reg <= ST_IDLE;
                ilc_reg <= 1'b0;
                nxm_reg <= 1'b0;
                rdy_reg <= 1'b1;
                rew_seen_reg <= 1'b0;
            end else if (cmd_wr) begin
                func_reg <= wmerge[C_FUNC +: 3];
                cma_reg[AW-1:16] <= wmerge[C_XADR +: 2];
                ie_reg <= wmerge[C_IE];
                unit_reg <= wmerge[C_UNIT +: 3];
                peven_reg <= wmerge[C_PEVEN];
                dens_reg <= wmerge[C_DENS +: 2];
                if (wmerge[C_UNIT +: 3] != unit_reg) begin
                    rew_seen_reg <= 1'b0;
                end
                if (wmerge[C_GO] & illegal) begin
                    ilc_reg <= 1'b1;
                end else if (wmerge[C_GO]) begin
                    rdy_reg <= 1'b0;
                    go_reg <= 1'b1;
                    ilc_reg <= 1'b0;
                    nxm_reg <= 1'b0;
                    last_reg <= 1'b0;
                    if (wmerge[C_FUNC +: 3] == F_WEOF) begin
                        buf_reg <= sev_f ? EOF7 : EOF9; // R13
                    end
                end
            end
            // Transport strobes while running.
            if (state_reg == ST_RUN) begin
                if (is_rd & rise_w[3] & ~last_reg) begin
                    rchr_reg <= chr_f;
                    buf_reg <= sev_f ? {2'b00, chr_f[5:0]} : chr_f[7:0]; // R5 R6 R16
                end
                if (((is_rd & rise_w[3]) | (is_wr & rise_w[2])) & ~last_reg) begin
                    brc_reg <= brc_inc; // R1
                    last_reg <= (brc_inc == ZERO16);
                end
                if (is_sp & rise_w[1]) begin
                    brc_reg <= brc_inc; // R2
                end
                if (is_rd & rise_w[1]) begin
                    if (~sev_f) begin
                        buf_reg <= csel_reg ? lrc_f : crc_f; // R8
                    end else if (csel_reg) begin
                        buf_reg <= lrc_f; // R9
                    end
                end
            end
            // Memory cycle completion.
            if ((state_reg == ST_BUS) & dma_err_i) begin
                nxm_reg <= 1'b1; // R4
            end else if ((state_reg == ST_BUS) & dma_ack_i) begin
                cma_reg <= cma_reg + ONE_A; // R3
                if (is_wr) begin
                    buf_reg <= cma_reg[0] ? dma_dat_i[15:8] : dma_dat_i[7:0]; // R17
                end
            end
        end
    end

    // Interrupt pending flag; a new event wins over an acknowledge in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0; // R25
            err_prev_reg <= 1'b0;
        end else if (ce_i) begin
            err_prev_reg <= err_w;
            if (rdy_rise | rew_done | (err_w & ~err_prev_reg) // R18 R19 R21
                | (cmd_wr & rdy_reg & ~wmerge[C_GO] & wmerge[C_IE]
                   & ~wmerge[C_PCLR])) begin // R20
                pend_reg <= 1'b1;
            end else if (irq_ack_i | cmd_wr) begin
                pend_reg <= 1'b0;
            end
        end
    end
    assign irq_o = ie_reg & pend_reg; // R18

    // DMA and transport outputs; handshake lines decode the state, data from registers.
    assign dma_req_o = (state_reg == ST_REQ);
    assign dma_cyc_o = (state_reg == ST_BUS);
    assign dma_we_o = is_rd; // R16
    assign dma_adr_o = cma_reg;
    assign dma_sel_o = cma_reg[0] ? 2'b10 : 2'b01; // R7
    assign dma_dat_o = {buf_reg, buf_reg};
    assign unit_sel_o = unit_reg;
    assign func_o = func_reg;
    assign go_pulse_o = go_reg;
    assign density_o = sev_f ? dens_reg : D_800; // R10
    assign parity_even_o = peven_reg; // R11
    // Extended gap erases ahead of a write; end-of-file gets its gap only without it.
    assign erase_gap_o = ext_gap_cmd | ((func_reg == F_WEOF) & ~ext_gap_cmd); // R12 R14
    assign wr_data_o = buf_reg;

    property p_ilc;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (cmd_wr && !rdy_reg) |=> (ilc_reg && cmd_rd[C_ERR]);
    endproperty
    a_ilc: assert property (p_ilc) else $error("illegal flag not set"); // R24

    property p_nogo;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (cmd_wr && rdy_reg && !wmerge[C_GO] && !wmerge[C_PCLR] && wmerge[C_IE]) |=> irq_o;
    endproperty
    a_nogo: assert property (p_nogo) else $error("no interrupt after command"); // R20

    property p_ie;
        @(posedge clk_i) disable iff (rst_i)
        !ie_reg |-> !irq_o;
    endproperty
    a_ie: assert property (p_ie) else $error("interrupt while disabled"); // R18

    property p_seven;
        @(posedge clk_i) disable iff (rst_i)
        (dma_cyc_o && dma_we_o && sev_f && $stable(sev_f)) |-> (buf_reg[7:6] == 2'b00);
    endproperty
    a_seven: assert property (p_seven) else $error("upper bits not zero"); // R5

    property p_nxm;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (dma_cyc_o && dma_err_i) |=> (cma_reg == $past(cma_reg) && nxm_reg && rdy_reg);
    endproperty
    a_nxm: assert property (p_nxm) else $error("address moved on error"); // R4

    property p_cma;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (dma_cyc_o && dma_ack_i && !dma_err_i) |=> (cma_reg == $past(cma_reg) + ONE_A);
    endproperty
    a_cma: assert property (p_cma) else $error("address not stepped"); // R3

    property p_rst;
        @(posedge clk_i) rst_i |=> (!dma_req_o && !dma_cyc_o && !irq_o);
    endproperty
    a_rst: assert property (p_rst) else $error("request after reset"); // R25

    property p_last;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (dma_cyc_o && dma_ack_i && last_reg) |=> (rdy_reg && brc_reg == ZERO16);
    endproperty
    a_last: assert property (p_last) else $error("count end not final"); // R1

    property p_dens;
        @(posedge clk_i) disable iff (rst_i)
        !sev_f |-> (density_o == D_800);
    endproperty
    a_dens: assert property (p_dens) else $error("nine-channel density"); // R10

    property p_lane;
        @(posedge clk_i) disable iff (rst_i)
        dma_cyc_o |-> (dma_sel_o == (dma_adr_o[0] ? 2'b10 : 2'b01));
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane mismatch"); // R7
endmodule : magtape_dma_controller

/* common/magtape_pkg.sv */
package magtape_pkg;
    // Register byte offsets on the Wishbone slave port.
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CMD = 8'h04;
    localparam logic [7:0] A_BRC = 8'h08;
    localparam logic [7:0] A_CMA = 8'h0c;
    localparam logic [7:0] A_DATA = 8'h10;
    localparam logic [7:0] A_RDL = 8'h14;
    // Command register field positions.
    localparam int C_GO = 0;
    localparam int C_FUNC = 1;
    localparam int C_XADR = 4;
    localparam int C_IE = 6;
    localparam int C_RDY = 7;
    localparam int C_UNIT = 8;
    localparam int C_PEVEN = 11;
    localparam int C_PCLR = 12;
    localparam int C_DENS = 13;
    localparam int C_ERR = 15;
    // Status register field positions.
    localparam int S_ILC = 15;
    localparam int S_NXM = 6;
    localparam int S_SELR = 5;
    localparam int S_BOT = 4;
    localparam int S_7CH = 3;
    localparam int S_RWS = 2;
    localparam int S_WRL = 1;
    // Read-lines register: check character select bit.
    localparam int R_CSEL = 14;
    // Function codes.
    localparam logic [2:0] F_OFFL = 3'h0;
    localparam logic [2:0] F_READ = 3'h1;
    localparam logic [2:0] F_WRITE = 3'h2;
    localparam logic [2:0] F_WEOF = 3'h3;
    localparam logic [2:0] F_SPFWD = 3'h4;
    localparam logic [2:0] F_SPREV = 3'h5;
    localparam logic [2:0] F_WEXT = 3'h6;
    localparam logic [2:0] F_REW = 3'h7;
    // Density codes; nine-channel always uses the 800 code.
    localparam logic [1:0] D_200 = 2'h0;
    localparam logic [1:0] D_556 = 2'h1;
    localparam logic [1:0] D_800 = 2'h2;
    // End-of-file mark characters (octal 17 and octal 23).
    localparam logic [7:0] EOF7 = 8'h0f;
    localparam logic [7:0] EOF9 = 8'h13;
    // Widths and reset values.
    localparam int AW = 18;
    localparam int NSYNC = 34;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [AW-1:0] ONE_A = 18'h00001;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [2:0] UNIT0 = 3'h0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_REQ = 4'b0100,
        ST_BUS = 4'b1000
    } seq_state_t;
endpackage : magtape_pkg

/* sim/mem_model.sv */
`timescale 1ns/1ps
// Memory and arbiter on the DMA side; it answers promptly or three cycles late.
module mem_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and bus cycle from the controller; slow_i from the testbench.
    input wire logic req_i,
    input wire logic slow_i,
    input wire logic cyc_i,
    input wire logic [17:0] adr_i,
    // Grant and answer.
    output logic gnt_o,
    output logic ack_o,
    output logic err_o,
    output logic [15:0] dat_o
);
    // Bytes from here up do not exist, so a cycle there ends in an error.
    localparam logic [17:0] ERR_BASE = 18'h08000;
    logic [1:0] cnt_reg;
    logic [15:0] word;
    // Each byte holds the low bits of its own address.
    assign word = {adr_i[7:1], 1'b1, adr_i[7:1], 1'b0};
    // Outside an answer the data lines toggle, so stale data cannot pass.
    always_ff @(posedge clk_i) begin
        gnt_o <= req_i & ~rst_i;
        dat_o <= rst_i ? 16'h0000 : ~dat_o;
        if (rst_i || !cyc_i || ack_o || err_o) begin
            cnt_reg <= 2'h0;
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else if (cnt_reg == (slow_i ? 2'h3 : 2'h0)) begin
            ack_o <= adr_i < ERR_BASE;
            err_o <= adr_i >= ERR_BASE;
            dat_o <= word;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
endmodule : mem_model

/* sim/magtape_dma_controller_tb.sv */
`timescale 1ns/1ps
// The driver queues expected memory writes; a monitor checks each as it lands.
module magtape_dma_controller_tb;
    import magtape_pkg::*;
    logic clk_i = 0, rst_i = 1, ce_i = 1, slow = 0, irq_ack_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, wr_data_o;
    logic [3:0] wb_sel_i = 4'h3, strb = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic dma_req_o, dma_gnt_i, dma_cyc_o, dma_we_o, dma_ack_i, dma_err_i, irq_o;
    logic [17:0] dma_adr_o;
    logic [1:0] dma_sel_o, density_o;
    logic [15:0] dma_dat_o, dma_dat_i, q;
    logic rewinding_i = 0, tape_start_marker_i = 0, write_lock_i = 0;
    logic seven_ch_i = 0, unit_ready_i = 1;
    logic [8:0] rd_char_i = 9'h0;
    logic [7:0] crc_char_i = 8'h0, lrc_char_i = 8'h0;
    logic [2:0] unit_sel_o, func_o;
    logic go_pulse_o, parity_even_o, erase_gap_o;
    wire read_strobe_i = strb[0];
    wire write_strobe_i = strb[1];
    wire eor_strobe_i = strb[2];
    wire op_done_i = strb[3];
    int failures = 0, checks_done = 0;
    logic [27:0] exp_q[$];

    // Free-running clock.
    always #10 clk_i = ~clk_i;

    magtape_dma_controller i_dut (.*);
    mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(dma_req_o), .slow_i(slow),
        .cyc_i(dma_cyc_o), .adr_i(dma_adr_o), .gnt_o(dma_gnt_i), .ack_o(dma_ack_i),
        .err_o(dma_err_i), .dat_o(dma_dat_i));

    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One classic bus cycle; read data is taken at the ack edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        wb(1'b0, a, 16'h0000);
        chk(q & m, e);
    endtask : rd

    // Strobes pass a pin filter, so each is held well beyond its latency.
    task automatic pulse(input int k);
        strb[k] <= 1'b1;
        repeat (8) @(posedge clk_i);
        strb[k] <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask : pulse

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done

    // Reads a record of n characters with a count of m from address 0x100.
    task automatic rx(input logic s, input logic c, input int n, input int m);
        logic [7:0] b;
        logic [8:0] ch;
        seven_ch_i <= s;
        slow <= 1'($urandom);
        wb(1'b1, A_RDL, {1'b0, c, 14'h0});
        wb(1'b1, A_BRC, 16'(-m));
        wb(1'b1, A_CMA, 16'h0100);
        wb(1'b1, A_CMD, 16'h0043);
        for (int i = 0; i < n; i++) begin
            ch = 9'($urandom);
            b = s ? {2'b00, ch[5:0]} : ch[7:0];
            rd_char_i <= ch;
            if (i < m) exp_q.push_back({18'h100 + 18'(i), i[0] ? 2'h2 : 2'h1, b});
            pulse(0);
        end
        if (n > m) begin
            rd(A_BRC, 16'hffff, 16'h0000);
            rd(A_CMA, 16'hffff, 16'h0100 + 16'(m));
        end else begin
            crc_char_i <= 8'($urandom);
            lrc_char_i <= 8'($urandom);
            pulse(2);
            rd(A_DATA, 16'h00ff, {8'h00, c ? lrc_char_i : (s ? b : crc_char_i)});
        end
        chk(irq_o, 1'b1);
        irq_ack_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        irq_ack_i <= 1'b0;
    endtask : rx

    // Writes m bytes from address a; the buffer must hold each fetched byte.
    task automatic tx(input logic [15:0] a, input int m, input logic [2:0] f);
        wb(1'b1, A_BRC, 16'(-m));
        wb(1'b1, A_CMA, a);
        wb(1'b1, A_CMD, {12'h000, f, 1'b1});
        for (int i = 0; i < m; i++) begin
            pulse(1);
            if (a < 16'h8000) chk(wr_data_o, 8'(a + 16'(i)));
        end
        chk(erase_gap_o, f == F_WEXT);
    endtask : tx

    // Every memory write is matched against the oldest queued note.
    always @(posedge clk_i) begin
        if (dma_cyc_o === 1'b1 && dma_we_o === 1'b1 && dma_ack_i === 1'b1)
            chk({dma_adr_o, dma_sel_o, dma_dat_o[7:0]},
                exp_q.size() > 0 ? exp_q.pop_front() : 28'hx);
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin : main
        void'($urandom(33));
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        rd(A_CMD, 16'hffff, 16'h4080);
        chk({dma_req_o, irq_o, unit_sel_o}, 28'h0);
        done("reset");
        rx(0, 0, 4, 3);
        rx(0, 0, 1, 8);
        rx(0, 1, 1, 8);
        rx(1, 1, 2, 8);
        rx(1, 0, 2, 8);
        done("read");
        tx(16'h0201, 2, F_WEXT);
        tx(16'h8000, 1, F_WRITE);
        rd(A_CMA, 16'hffff, 16'h8000);
        rd(A_STATUS, 16'h0040, 16'h0040);
        done("write");
        seven_ch_i <= 1;
        repeat (8) @(posedge clk_i);
        for (int d = 0; d < 3; d++) begin
            wb(1'b1, A_CMD, {1'b0, 2'(d), 1'b0, d[0], 11'h0});
            @(posedge clk_i);
            chk({density_o, parity_even_o}, {2'(d), d[0]});
        end
        seven_ch_i <= 0;
        repeat (8) @(posedge clk_i);
        wb(1'b1, A_CMD, 16'h0000);
        @(posedge clk_i);
        chk(density_o, D_800);
        wb(1'b1, A_CMD, 16'h0540);
        repeat (2) @(posedge clk_i);
        chk({irq_o, unit_sel_o}, 28'hd);
        wb(1'b1, A_CMD, 16'h1000);
        repeat (2) @(posedge clk_i);
        chk({irq_o, unit_sel_o}, 28'h0);
        done("control");
        for (int s = 0; s < 2; s++) begin
            seven_ch_i <= s[0];
            repeat (8) @(posedge clk_i);
            wb(1'b1, A_CMD, 16'h0007);
            @(posedge clk_i);
            chk({go_pulse_o, erase_gap_o, func_o}, {2'b11, F_WEOF});
            @(posedge clk_i);
            chk(wr_data_o, s[0] ? EOF7 : EOF9);
            pulse(3);
        end
        wb(1'b1, A_CMD, 16'h004f);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b1);
        irq_ack_i <= 1'b1;
        rewinding_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        irq_ack_i <= 1'b0;
        chk(irq_o, 1'b0);
        rewinding_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wb(1'b1, A_BRC, 16'hfffe);
        wb(1'b1, A_CMD, 16'h0009);
        pulse(2);
        pulse(2);
        rd(A_BRC, 16'hffff, 16'h0000);
        rd(A_CMD, 16'h0080, 16'h0080);
        wb(1'b1, A_BRC, 16'hfff0);
        wb(1'b1, A_CMD, 16'h0003);
        wb(1'b1, A_CMD, 16'h0000);
        rd(A_STATUS, 16'h8000, 16'h8000);
        rd(A_CMD, 16'h8080, 16'h8000);
        pulse(3);
        unit_ready_i <= 0;
        repeat (8) @(posedge clk_i);
        rd(A_STATUS, 16'h0020, 16'h0000);
        done("errors");
        give_verdict();
    end

    // A hang counts as a mismatch and ends the run.
    initial begin : watchdog
        #(20 * 30000);
        failures++;
        give_verdict();
    end
endmodule : magtape_dma_controller_tb
